// file: tecpr_pkg.sv
// constants, types and register map of the timer clock front end
`default_nettype none
package tecpr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h23;
  localparam logic [7:0] SEL_IDX = 8'h24;
  localparam logic [7:0] STAT_IDX = 8'h25;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;

  // global_timer_sync_control field positions and reset value, and the select reset value
  localparam int unsigned HOLD_BIT = 7;
  localparam int unsigned ASYNC_RST_BIT = 1;
  localparam int unsigned SYNC_RST_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // status register field position
  localparam int unsigned STAT_PIN_BIT = 16;

  // tick source select width and prescaler taps
  localparam int unsigned SEL_W = 3;
  localparam int unsigned PRESC_W = 10;
  localparam int unsigned TAP_DIV8 = 3;
  localparam int unsigned TAP_DIV64 = 6;
  localparam int unsigned TAP_DIV256 = 8;
  localparam int unsigned TAP_DIV1024 = 10;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // tick source select codes in ascending order, 0 to 7
  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_CLK,
    SRC_DIV8,
    SRC_DIV64,
    SRC_DIV256,
    SRC_DIV1024,
    SRC_FALL,
    SRC_RISE
  } tecpr_src_t;

  // captured address phase of a bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] idx;
  } tecpr_acc_t;

  // prescaler reset controls
  typedef struct packed {
    logic hold;
    logic async_rst;
    logic sync_rst;
  } tecpr_ctrl_t;

endpackage
`default_nettype wire

// file: tecpr_pulse_src.sv
// external pulse source model driving the count pin
`timescale 1ns/1ps
`default_nettype none
module tecpr_pulse_src #(
  parameter int HALF_CYC = 2
) (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  output logic pin_o,
  output logic busy_o
);
  // two-cycle phases exceed one cycle; a four-cycle period stays under
  // the system clock over 2.5
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        repeat (pulses_i) begin
          pin_o <= 1'b1;
          repeat (HALF_CYC) @(posedge clk_i);
          pin_o <= 1'b0;
          repeat (HALF_CYC) @(posedge clk_i);
        end
        // pin is left low and stable between bursts
        busy_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tecpr_top.sv
// timer clock front end: pin sampling, tick select, prescaler reset control
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tecpr_top
  import tecpr_pkg::*;
#(
  parameter int unsigned NUM_TIMERS = 5
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic EXT_COUNT_PIN_I,
  input wire logic ASYNC_MODE_I,
  input wire logic ASYNC_RESET_DONE_I,
  output logic SHARED_PRESCALER_RESET_O,
  output logic ASYNC_PRESCALER_RESET_O,
  output logic [NUM_TIMERS-1:0] TIMER_TICK_O
);

  localparam int unsigned SELS_W = NUM_TIMERS * SEL_W;

  tecpr_acc_t acc_reg, acc_next;
  tecpr_ctrl_t ctrl_reg, ctrl_next;
  logic [SELS_W-1:0] sel_reg, sel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic front_reg;
  logic sync_a_reg, sync_b_reg;
  logic [NUM_TIMERS-1:0] tick_reg, tick_next;
  logic wr_ctrl, wr_sel;
  logic rise, fall;
  logic async_busy;
  logic [3:0] tap;

  // ---------------- bus slave ----------------
  // always ready, always okay: every register answers in zero wait states
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = HRESP_OKAY;
  assign HRDATA_O = rdata_reg;

  assign wr_ctrl = acc_reg.valid && acc_reg.write && (acc_reg.idx == CTRL_IDX);
  assign wr_sel = acc_reg.valid && acc_reg.write && (acc_reg.idx == SEL_IDX);

  always_comb begin
    acc_next.valid = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);
    acc_next.write = HWRITE_I;
    acc_next.idx = HADDR_I[IDX_LSB +: IDX_W];
  end

  // read data is built from next values so a read right behind a write
  // returns the freshly written contents
  always_comb begin
    rdata_next = rdata_reg;
    if (acc_next.valid && !acc_next.write) begin
      case (acc_next.idx)
        CTRL_IDX: begin
          rdata_next = 32'h0000_0000;
          rdata_next[HOLD_BIT] = ctrl_next.hold;
          rdata_next[ASYNC_RST_BIT] = ctrl_next.async_rst;
          rdata_next[SYNC_RST_BIT] = ctrl_next.sync_rst;
        end
        SEL_IDX: begin
          rdata_next = 32'(sel_next);
        end
        STAT_IDX: begin
          rdata_next = 32'(presc_next);
          rdata_next[STAT_PIN_BIT] = sync_b_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      acc_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- prescaler reset control ----------------
  // in async mode the async reset bit stays up until the async side reports it is done
  assign async_busy = ASYNC_MODE_I && !ASYNC_RESET_DONE_I;

  // a software write wins over the hardware clear in the same cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      // bits 6-2 have no storage, so writes to them vanish
      ctrl_next.hold = HWDATA_I[HOLD_BIT];
      ctrl_next.async_rst = HWDATA_I[ASYNC_RST_BIT];
      ctrl_next.sync_rst = HWDATA_I[SYNC_RST_BIT];
    end else if (!ctrl_reg.hold) begin
      // without hold the shared bit drops after one cycle of reset, the async bit once async_busy is low
      ctrl_next.sync_rst = 1'b0;
      if (!async_busy) begin
        ctrl_next.async_rst = 1'b0;
      end
    end
    // with hold set both bits simply keep their written value
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ctrl_reg <= tecpr_ctrl_t'(3'h0);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign SHARED_PRESCALER_RESET_O = ctrl_reg.sync_rst;
  assign ASYNC_PRESCALER_RESET_O = ctrl_reg.async_rst;

  // ---------------- tick source selects ----------------
  always_comb begin
    sel_next = sel_reg;
    if (wr_sel) begin
      sel_next = HWDATA_I[SELS_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sel_reg <= SEL_RESET[SELS_W-1:0];
    end else begin
      sel_reg <= sel_next;
    end
  end

  // ---------------- shared prescaler ----------------
  // free running, held at zero while its reset bit is up
  always_comb begin
    if (ctrl_reg.sync_rst) begin
      presc_next = '0;
    end else begin
      presc_next = presc_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // a tap fires in the last cycle of each divided period
  assign tap[0] = &presc_reg[TAP_DIV8-1:0];
  assign tap[1] = &presc_reg[TAP_DIV64-1:0];
  assign tap[2] = &presc_reg[TAP_DIV256-1:0];
  assign tap[3] = &presc_reg[TAP_DIV1024-1:0];

  // ---------------- pin synchroniser and edge detector ----------------
  // the front stage closes on the falling edge, standing in for a latch
  // open during clock high; this gives the half cycle of the latency
  always_ff @(negedge CLK_I) begin
    if (!RESET_N_I) begin
      front_reg <= 1'b0;
    end else begin
      front_reg <= EXT_COUNT_PIN_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
    end else begin
      sync_a_reg <= front_reg;
      sync_b_reg <= sync_a_reg;
    end
  end

  // sampling only catches phases longer than a clock
  assign rise = sync_a_reg && !sync_b_reg;
  assign fall = !sync_a_reg && sync_b_reg;

  // ---------------- tick generation per timer ----------------
  // changing a select while the pin moves can give a false tick
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tick
      tecpr_src_t src;
      assign src = tecpr_src_t'(sel_reg[i*SEL_W +: SEL_W]);
      always_comb begin
        case (src)
          SRC_STOP: tick_next[i] = 1'b0;
          SRC_CLK: tick_next[i] = !ctrl_reg.sync_rst;
          SRC_DIV8: tick_next[i] = !ctrl_reg.sync_rst && tap[0];
          SRC_DIV64: tick_next[i] = !ctrl_reg.sync_rst && tap[1];
          SRC_DIV256: tick_next[i] = !ctrl_reg.sync_rst && tap[2];
          SRC_DIV1024: tick_next[i] = !ctrl_reg.sync_rst && tap[3];
          SRC_FALL: tick_next[i] = fall;
          SRC_RISE: tick_next[i] = rise;
          default: tick_next[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  // the counter consumes the tick at the next edge
  assign TIMER_TICK_O = tick_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  logic [SEL_W-1:0] sel0;
  assign sel0 = sel_reg[SEL_W-1:0];

  property p_pin_to_tick;
    $rose(front_reg) && sel0 == 3'h7 && $stable(sel0) ##1 $stable(sel0)
      |-> ##1 tick_reg[0];
  endproperty
  a_pin_to_tick: assert property (p_pin_to_tick)
    else $error("sampled rising pin did not tick in time");

  property p_rise_tick;
    (sel0 == 3'h7) && sync_a_reg && !sync_b_reg |=> tick_reg[0];
  endproperty
  a_rise_tick: assert property (p_rise_tick)
    else $error("rising edge gave no tick");

  property p_fall_tick;
    (sel0 == 3'h6) && !sync_a_reg && sync_b_reg |=> tick_reg[0];
  endproperty
  a_fall_tick: assert property (p_fall_tick)
    else $error("falling edge gave no tick");

  property p_single_tick;
    (sel0 == 3'h7) && $stable(sel0) && tick_reg[0] |-> !tick_next[0];
  endproperty
  a_single_tick: assert property (p_single_tick)
    else $error("one edge gave two ticks");

  property p_sync_chain;
    sync_b_reg == $past(front_reg, 2);
  endproperty
  a_sync_chain: assert property (p_sync_chain)
    else $error("synchroniser depth wrong");

  property p_direct;
    (sel0 == 3'h1) && !ctrl_reg.sync_rst |=> tick_reg[0];
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct clock select did not tick");

  property p_stop;
    (sel0 == 3'h0) |=> !tick_reg[0];
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped timer ticked");

  property p_div8;
    (sel0 == 3'h2) && !ctrl_reg.sync_rst |=> tick_reg[0] == $past(tap[0]);
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by 8 tick wrong");

  property p_hold_keeps;
    ctrl_reg.hold && !wr_ctrl |=> $stable(ctrl_reg);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps)
    else $error("hold mode lost a prescaler reset bit");

  property p_release;
    wr_ctrl && !HWDATA_I[HOLD_BIT] ##1 !wr_ctrl |=> !ctrl_reg.sync_rst;
  endproperty
  a_release: assert property (p_release)
    else $error("clearing hold left shared reset set");

  property p_sync_autoclr;
    !ctrl_reg.hold && ctrl_reg.sync_rst && !wr_ctrl
      |=> !ctrl_reg.sync_rst && presc_reg == '0;
  endproperty
  a_sync_autoclr: assert property (p_sync_autoclr)
    else $error("shared reset did not clear or reset the prescaler");

  property p_async_busy;
    ctrl_reg.async_rst && async_busy && !wr_ctrl |=> ctrl_reg.async_rst;
  endproperty
  a_async_busy: assert property (p_async_busy)
    else $error("async reset bit dropped before completion");

  // only a control read carries reserved bits; other registers use 6:2
  property p_reserved;
    acc_reg.valid && !acc_reg.write && (acc_reg.idx == CTRL_IDX)
      |-> rdata_reg[HOLD_BIT-1:ASYNC_RST_BIT+1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  c_rise: cover property ((sel0 == 3'h7) ##0 rise ##1 tick_reg[0]);
  c_hold: cover property (ctrl_reg.hold && ctrl_reg.sync_rst ##1 !ctrl_reg.hold);
  c_async: cover property (ctrl_reg.async_rst && async_busy ##1 ctrl_reg.async_rst);
  c_div1024: cover property ((sel0 == 3'h5) && tick_reg[0]);

endmodule
`default_nettype wire

// file: timer_ext_clock_and_prescaler_reset_test.sv
// testbench for the timer clock front end
`timescale 1ns/1ps
`default_nettype none
module timer_ext_clock_and_prescaler_reset_test import tecpr_pkg::*;;
  localparam logic [31:0] A_CTRL = {22'h0, CTRL_IDX, 2'h0};
  localparam logic [31:0] A_SEL = {22'h0, SEL_IDX, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, STAT_IDX, 2'h0};
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, go = 0;
  logic amode = 0, adone = 0, hready, hresp, pin, busy, srst, arst;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, sel;
  logic [4:0] tick;
  int err_total = 0, comparisons = 0, cyc = 0;
  int cnt[5];
  realtime t_rise, t_tick;

  always #20 clk = ~clk;

  tecpr_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .EXT_COUNT_PIN_I(pin), .ASYNC_MODE_I(amode),
    .ASYNC_RESET_DONE_I(adone), .SHARED_PRESCALER_RESET_O(srst),
    .ASYNC_PRESCALER_RESET_O(arst), .TIMER_TICK_O(tick));

  tecpr_pulse_src src (.clk_i(clk), .go_i(go), .pulses_i(8'h05),
    .pin_o(pin), .busy_o(busy));

  // ticks counted mid-cycle, where they have settled
  always @(negedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (tick[i] === 1'b1) cnt[i]++;
    end
  end
  always @(posedge pin) t_rise = $realtime;
  always @(posedge tick[0]) t_tick = $realtime;

  // ceiling well above the roughly 2100 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("counts: %0d mismatches in %0d comparisons", err_total,
      comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g,
                         input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic chk_cnt(input int e, input int g, input string m);
    comparisons++;
    if (g != e) begin
      err_total++;
      $display("mismatch at %0t: %s got %0d want %0d", $time, m, g, e);
    end
  endtask

  // one single word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                        input string m);
    bus(1'b0, a, 32'h0);
    chk_reg(e, rd, m);
    chk_reg({31'h0, HRESP_OKAY}, {31'h0, hresp}, "response");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // counts the ticks of the n cycles after the next rising edge
  task automatic win(input int n);
    @(posedge clk);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (n) @(posedge clk);
  endtask

  task automatic burst();
    win(0);
    go <= 1'b1;
    idle(8);
    go <= 1'b0;
    while (busy === 1'b1) @(posedge clk);
    idle(6);
  endtask

  initial begin
    idle(16);
    rst_n <= 1'b1;
    idle(1);
    rd_chk(A_CTRL, {24'h0, CTRL_RESET}, "ctrl reset");
    rd_chk(A_SEL, SEL_RESET, "select reset");
    rd_chk(32'h0, 32'h0, "unmapped read");
    $display("test reset values done");
    bus(1'b1, A_CTRL, 32'hFFFF_FFFF);
    rd_chk(A_CTRL, 32'h83, "hold keeps bits");
    chk_reg(32'h3, {30'h0, arst, srst}, "resets held");
    bus(1'b1, A_CTRL, 32'h0);
    idle(2);
    rd_chk(A_CTRL, 32'h0, "hold release");
    chk_reg(32'h0, {30'h0, arst, srst}, "resets freed");
    bus(1'b1, A_CTRL, 32'h1);
    rd_chk(A_STAT, 32'h0, "prescaler cleared");
    idle(2);
    rd_chk(A_CTRL, 32'h0, "shared reset clears");
    $display("test hold done");
    amode <= 1'b1;
    bus(1'b1, A_CTRL, 32'h2);
    idle(3);
    rd_chk(A_CTRL, 32'h2, "async reset pending");
    chk_reg(32'h1, {31'h0, arst}, "async reset out");
    adone <= 1'b1;
    idle(3);
    rd_chk(A_CTRL, 32'h0, "async reset done");
    amode <= 1'b0;
    adone <= 1'b0;
    bus(1'b1, A_CTRL, 32'h2);
    idle(2);
    rd_chk(A_CTRL, 32'h0, "async reset clears");
    $display("test async reset done");
    // select changes only while the pin is idle and stable
    sel = {17'h0, SRC_STOP, SRC_DIV8, SRC_RISE, SRC_FALL, SRC_CLK};
    bus(1'b1, A_SEL, sel);
    rd_chk(A_SEL, sel, "select readback");
    win(800);
    chk_cnt(800, cnt[0], "system clock ticks");
    chk_cnt(0, cnt[1], "idle pin falling ticks");
    chk_cnt(0, cnt[2], "idle pin rising ticks");
    chk_cnt(100, cnt[3], "div8 ticks");
    chk_cnt(0, cnt[4], "stopped ticks");
    $display("test internal sources done");
    sel = {17'h0, SRC_STOP, SRC_DIV8, SRC_CLK, SRC_FALL, SRC_RISE};
    bus(1'b1, A_SEL, sel);
    burst();
    chk_cnt(5, cnt[0], "rising ticks");
    chk_cnt(5, cnt[1], "falling ticks");
    chk_cnt(1, int'(t_tick + 40 - t_rise >= 100 &&
      t_tick + 40 - t_rise <= 140), "pin latency");
    $display("test external pin done");
    sel = {17'h0, SRC_DIV256, SRC_DIV64, SRC_DIV8, SRC_CLK, SRC_DIV1024};
    bus(1'b1, A_SEL, sel);
    win(1024);
    chk_cnt(1, cnt[0], "div1024 ticks");
    chk_cnt(1024, cnt[1], "clk ticks");
    chk_cnt(128, cnt[2], "div8 ticks");
    chk_cnt(16, cnt[3], "div64 ticks");
    chk_cnt(4, cnt[4], "div256 ticks");
    $display("test prescaler taps done");
    sel = {17'h0, SRC_RISE, SRC_DIV64, SRC_FALL, SRC_CLK, SRC_DIV8};
    bus(1'b1, A_SEL, sel);
    bus(1'b1, A_CTRL, 32'h81);
    win(80);
    chk_cnt(0, cnt[0], "held div8 ticks");
    chk_cnt(0, cnt[1], "held clk ticks");
    chk_cnt(0, cnt[3], "held div64 ticks");
    bus(1'b1, A_CTRL, 32'h0);
    win(80);
    chk_cnt(10, cnt[0], "resumed div8 ticks");
    chk_cnt(80, cnt[1], "resumed clk ticks");
    chk_cnt(1, cnt[3], "resumed div64 ticks");
    $display("test synchronised start done");
    sel = {17'h0, SRC_STOP, SRC_STOP, SRC_STOP, SRC_RISE, SRC_FALL};
    bus(1'b1, A_SEL, sel);
    burst();
    chk_cnt(5, cnt[0], "falling ticks on timer 0");
    chk_cnt(5, cnt[1], "rising ticks on timer 1");
    chk_cnt(0, cnt[2], "stopped ticks");
    $display("test falling edge done");
    end_sim();
  end
endmodule
`default_nettype wire
